/* File: logic/sar_defines.svh */
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

// ****************************************
// conversion geometry
// ****************************************
`define SAR_BITS            8
`define SAR_LONG_BITS       4

// ****************************************
// timing, times in ns except SAR_SYNC_STAGES, which counts clocks
// ****************************************
`define SAR_CLOCK_NS        50
`define SAR_MSB_SETTLE_NS   85
`define SAR_LSB_SETTLE_NS   35
`define SAR_LONG_TRIAL_NS   160
`define SAR_SHORT_TRIAL_NS  80
`define SAR_SYNC_STAGES     2

// least times round up; the comparator synchroniser delay is added on top
`define SAR_LONG_CYCLES  ((`SAR_LONG_TRIAL_NS + `SAR_CLOCK_NS - 1) / `SAR_CLOCK_NS \
                          + `SAR_SYNC_STAGES)
`define SAR_SHORT_CYCLES ((`SAR_SHORT_TRIAL_NS + `SAR_CLOCK_NS - 1) / `SAR_CLOCK_NS \
                          + `SAR_SYNC_STAGES)

`endif

/* File: logic/sar_types_pkg.sv */
package sar_types_pkg;

   // conversion phases
   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_TRIAL,
      ST_SETTLE,
      ST_DONE
   } sar_state_t;

endpackage : sar_types_pkg

/* File: logic/trial_timer.sv */
`timescale 1ns/100ps
`include "sar_defines.svh"

module trial_timer
#(
   parameter int unsigned LONG_CYCLES  = `SAR_LONG_CYCLES,
   parameter int unsigned SHORT_CYCLES = `SAR_SHORT_CYCLES
)
(
   // clock and reset
   input  wire logic clock,
   input  wire logic resetSync_n,
   input  wire logic clockEnable,
   // control
   input  wire logic restart,
   input  wire logic longSel,
   input  wire logic active,
   // status
   output logic      expired
);

   localparam int unsigned CW = $clog2(LONG_CYCLES);

   logic [CW-1:0] count_ff;

   // ****************************************
   // period counter
   // ****************************************
   // period covers dac settling, comparator delay and the synchroniser
   always_ff @(posedge clock or negedge resetSync_n)
   begin
      if (!resetSync_n)
         count_ff <= '0;
      else if (clockEnable)
      begin
         if (restart)
            count_ff <= longSel ? CW'(LONG_CYCLES - 1) : CW'(SHORT_CYCLES - 1);
         else if (count_ff != '0)
            count_ff <= count_ff - 1'b1;
      end
   end

   assign expired = active && (count_ff == '0);

endmodule // trial_timer

/* File: logic/sar_conversion_logic.sv */
// Contract
// - first trial drives only the most significant dac bit, half scale
// - input above trial value keeps the bit, next lower bit tried with it
// - input below trial value clears the bit before the next trial
// - trials run msb to lsb, one per bit, n trials in all
// - a conversion takes n trial periods plus one clock
// - start loads a single one into the sequencer, sets msb latch and dac msb
// - latch keeps its one while comparator is low, else cleared before next trial
// - each step advances the single one by one stage until all bits tried
// - after the last trial end-of-conversion goes high, result valid
// - eight-bit conversion is eight trial periods plus one clock
// - trial period covers dac settling, comparator delay, logic delay
// - trial period allows longest settling at msb, shortest at lsb
// - conversion begins when start is sampled high on a rising clock
// - init pulse clears result except msb set, and loads the sequencer with msb only
// - four upper bits get longer trial periods than four lower bits
`timescale 1ns/100ps
`include "sar_defines.svh"

module sar_conversion_logic
#(
   parameter int unsigned DATA_BITS    = `SAR_BITS,
   parameter int unsigned LONG_BITS    = `SAR_LONG_BITS,
   parameter int unsigned LONG_CYCLES  = `SAR_LONG_CYCLES,
   parameter int unsigned SHORT_CYCLES = `SAR_SHORT_CYCLES
)
(
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   input  wire logic                 clockEnable,
   // user side
   input  wire logic                 startIn,
   output logic [DATA_BITS-1:0]      resultData,
   output logic                      endOfConv,
   output logic                      initStrobe,
   output sar_types_pkg::sar_state_t convPhase,
   // converter side
   output logic [DATA_BITS-1:0]      dacBits,
   input  wire logic                 comparatorIn
);

   import sar_types_pkg::*;

   localparam logic [DATA_BITS-1:0] MSB_ONLY = {1'b1, {(DATA_BITS-1){1'b0}}};
   localparam int unsigned CONV_CYCLES =
      LONG_BITS * LONG_CYCLES + (DATA_BITS - LONG_BITS) * SHORT_CYCLES;
   localparam int unsigned CCW = $clog2(CONV_CYCLES + 2);

   // ****************************************
   // declarations
   // ****************************************
   logic [1:0]           resetPipe_ff;
   logic                 resetSync_n;
   logic [1:0]           startPipe_ff;
   logic [1:0]           compPipe_ff;
   logic                 startSync;
   logic                 compSync;
   sar_state_t           state_ff;
   logic [DATA_BITS-1:0] result_ff;
   logic [DATA_BITS-1:0] seq_ff;
   logic                 eoc_ff;
   logic                 strobe_ff;
   logic                 startAcc;
   logic                 tick;
   logic                 lastBit;
   logic [DATA_BITS-1:0] nextSeq;
   logic                 restart;
   logic                 longSel;
   logic [CCW-1:0]       convCnt_ff;

   // ****************************************
   // reset release
   // ****************************************
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         resetPipe_ff <= 2'h0;
      else if (clockEnable)
         resetPipe_ff <= {resetPipe_ff[0], 1'b1};
   end

   assign resetSync_n = resetPipe_ff[1];

   // ****************************************
   // pin synchronisers
   // ****************************************
   // the comparator is asynchronous to us; its two stages are part of the trial
   always_ff @(posedge clock or negedge resetSync_n)
   begin
      if (!resetSync_n)
      begin
         startPipe_ff <= 2'h0;
         compPipe_ff  <= 2'h0;
      end
      else if (clockEnable)
      begin
         startPipe_ff <= {startPipe_ff[0], startIn};
         compPipe_ff  <= {compPipe_ff[0], comparatorIn};
      end
   end

   assign startSync = startPipe_ff[1];
   assign compSync  = compPipe_ff[1];

   // ****************************************
   // sequencing decodes
   // ****************************************
   // start is a level; held high from end-of-conversion it restarts at once
   assign startAcc = startSync && ((state_ff == ST_IDLE) || (state_ff == ST_DONE));
   assign lastBit  = seq_ff[0];
   assign nextSeq  = seq_ff >> 1;
   assign restart  = startAcc || (tick && !lastBit);
   // upper bits settle slowest, so they get the long period
   assign longSel  = startAcc || (|nextSeq[DATA_BITS-1 -: LONG_BITS]);

   trial_timer
   #(
      .LONG_CYCLES  (LONG_CYCLES),
      .SHORT_CYCLES (SHORT_CYCLES)
   )
   u_trial_timer
   (
      .clock       (clock),
      .resetSync_n (resetSync_n),
      .clockEnable (clockEnable),
      .restart     (restart),
      .longSel     (longSel),
      .active      (state_ff == ST_TRIAL),
      .expired     (tick)
   );

   // ****************************************
   // conversion phase
   // ****************************************
   always_ff @(posedge clock or negedge resetSync_n)
   begin
      if (!resetSync_n)
         state_ff <= ST_IDLE;
      else if (clockEnable)
      begin
         unique case (state_ff)
            ST_IDLE, ST_DONE:
               if (startSync)
                  state_ff <= ST_TRIAL;
            ST_TRIAL:
               if (tick && lastBit)
                  state_ff <= ST_SETTLE;
            ST_SETTLE:
               state_ff <= ST_DONE;
         endcase
      end
   end

   // ****************************************
   // bit sequencer
   // ****************************************
   always_ff @(posedge clock or negedge resetSync_n)
   begin
      if (!resetSync_n)
         seq_ff <= '0;
      else if (clockEnable)
      begin
         if (startAcc)
            seq_ff <= MSB_ONLY;
         else if (tick)
            seq_ff <= nextSeq;
      end
   end

   // ****************************************
   // result latches
   // ****************************************
   // comparator high means the trial overshot the input
   always_ff @(posedge clock or negedge resetSync_n)
   begin
      if (!resetSync_n)
         result_ff <= '0;
      else if (clockEnable)
      begin
         if (startAcc)
            result_ff <= MSB_ONLY;
         else if (tick)
         begin
            if (compSync)
               result_ff <= (result_ff & ~seq_ff) | nextSeq;
            else
               result_ff <= result_ff | nextSeq;
         end
      end
   end

   // ****************************************
   // end of conversion and init strobe
   // ****************************************
   always_ff @(posedge clock or negedge resetSync_n)
   begin
      if (!resetSync_n)
         eoc_ff <= 1'b0;
      else if (clockEnable)
      begin
         if (state_ff == ST_SETTLE)
            eoc_ff <= 1'b1;
         else if (startAcc)
            eoc_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetSync_n)
   begin
      if (!resetSync_n)
         strobe_ff <= 1'b0;
      else if (clockEnable)
         strobe_ff <= startAcc;
   end

   // ****************************************
   // outputs
   // ****************************************
   // the dac sees the latches directly; no extra delay in the loop
   assign dacBits    = result_ff;
   assign resultData = result_ff;
   assign endOfConv  = eoc_ff;
   assign initStrobe = strobe_ff;
   assign convPhase  = state_ff;

   // ****************************************
   // checks
   // ****************************************
   // counts trial cycles of the running conversion, read by checks only
   always_ff @(posedge clock or negedge resetSync_n)
   begin
      if (!resetSync_n)
         convCnt_ff <= '0;
      else if (clockEnable)
      begin
         if (startAcc)
            convCnt_ff <= '0;
         else if (state_ff == ST_TRIAL)
            convCnt_ff <= convCnt_ff + 1'b1;
      end
   end

   a_first_trial_msb:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      startAcc |=> (dacBits == MSB_ONLY) && (seq_ff == MSB_ONLY) && initStrobe)
      else $error("first trial does not drive msb alone");

   a_keep_on_low:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (tick && !compSync) |=> ((result_ff & $past(seq_ff)) == $past(seq_ff)))
      else $error("bit under trial lost with comparator low");

   a_clear_on_high:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (tick && compSync) |=> ((result_ff & $past(seq_ff)) == '0))
      else $error("bit under trial kept with comparator high");

   a_single_one:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (state_ff == ST_TRIAL) |-> $onehot(seq_ff) && ((result_ff & (seq_ff - 1'b1)) == '0))
      else $error("sequencer not one-hot or lower bits set early");

   a_shift_advance:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (tick && !lastBit) |=> (seq_ff == ($past(seq_ff) >> 1)) && (state_ff == ST_TRIAL))
      else $error("sequencer did not advance one stage");

   a_eoc_after_last:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (tick && lastBit) |=> !endOfConv ##1 endOfConv)
      else $error("end of conversion not one clock after last trial");

   a_long_trial:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (restart && longSel) |=> !tick [*5] ##1 tick)
      else $error("long trial period wrong");

   a_short_trial:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (restart && !longSel) |=> !tick [*3] ##1 tick)
      else $error("short trial period wrong");

   a_conv_length:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (state_ff == ST_SETTLE) |-> (convCnt_ff == CCW'(CONV_CYCLES)))
      else $error("conversion length wrong");

   a_result_stable:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      (endOfConv && !startAcc) |=> $stable(resultData) && endOfConv)
      else $error("result moved while end of conversion high");

   a_start_taken:
   assert property (@(posedge clock) disable iff (!resetSync_n || !clockEnable)
      ($rose(startSync) && (state_ff == ST_IDLE)) |=> (state_ff == ST_TRIAL) && !endOfConv)
      else $error("start sampled high but no conversion began");

endmodule // sar_conversion_logic

/* File: tb/dac_comparator_model.sv */
`timescale 1ns/100ps
module dac_comparator_model
(
   // timing
   input  wire logic       clock,
   input  wire logic [1:0] lagCycles,
   // analog input, as an ideal code
   input  wire logic [7:0] vinCode,
   // converter side
   input  wire logic [7:0] dacBits,
   output logic            comparatorIn
);
   logic [7:0] lastDac_ff;
   logic [1:0] held_ff;
   logic [1:0] age;
   logic       staleOut_ff;

   assign age = (dacBits !== lastDac_ff) ? 2'h0 : held_ff;
   // high means input below trial value; unsettled output is not kept, it flips
   assign comparatorIn = (age >= lagCycles) ? (dacBits > vinCode) : ~staleOut_ff;

   always_ff @(posedge clock)
   begin
      lastDac_ff  <= dacBits;
      staleOut_ff <= comparatorIn;
      held_ff     <= (dacBits !== lastDac_ff) ? 2'h1
                   : ((held_ff == 2'h3) ? 2'h3 : held_ff + 2'h1);
   end
endmodule // dac_comparator_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import sar_types_pkg::*;
   logic       clock;
   logic       reset_n;
   logic       clockEnable;
   logic       startReg;
   logic       loopMode;
   logic       startIn;
   logic [7:0] vinCode;
   logic [1:0] lagCycles;
   logic [7:0] resultData;
   logic [7:0] dacBits;
   logic [7:0] snap;
   logic       endOfConv;
   logic       initStrobe;
   logic       comparatorIn;
   sar_state_t convPhase;
   int         fails = 0;
   int         nCompared = 0;

   // continuous mode: end-of-conversion wired back to start
   assign startIn = loopMode ? endOfConv : startReg;

   sar_conversion_logic DUT (.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable),
      .startIn(startIn), .resultData(resultData), .endOfConv(endOfConv),
      .initStrobe(initStrobe), .convPhase(convPhase), .dacBits(dacBits),
      .comparatorIn(comparatorIn));
   dac_comparator_model partner (.clock(clock), .lagCycles(lagCycles), .vinCode(vinCode),
      .dacBits(dacBits), .comparatorIn(comparatorIn));

   // ****
   // helpers
   // ****
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      nCompared++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // dac pattern in cycle t after the taking edge
   function automatic logic [7:0] trial_value(input logic [7:0] code, input int t);
      int b;
      if (t >= 41)
         return code;
      b = (t <= 24) ? 7 - (t - 1) / 6 : 3 - (t - 25) / 4;
      return (code & (8'hFF << (b + 1))) | (8'h01 << b);
   endfunction

   // ****
   // scenarios
   // ****
   task automatic convert(input logic [7:0] code, input logic [1:0] lag, input bit midStart);
      @(posedge clock);
      vinCode   <= code;
      lagCycles <= lag;
      startReg  <= 1'b1;
      @(posedge clock) startReg <= 1'b0;
      tick(1);
      check(initStrobe, 1'b0, "early strobe");
      for (int t = 1; t <= 42; t++)
      begin
         @(posedge clock);
         startReg <= (t == 10) && midStart;
         #1;
         check(dacBits, trial_value(code, t), "dac pattern");
         check(initStrobe, t == 1, "init strobe");
         check(endOfConv, t == 42, "end of conversion");
         if (t == 1)
            check({6'h0, convPhase}, {6'h0, ST_TRIAL}, "phase trial");
         if (t == 41)
            check({6'h0, convPhase}, {6'h0, ST_SETTLE}, "phase settle");
      end
      check({6'h0, convPhase}, {6'h0, ST_DONE}, "phase done");
      repeat (6)
      begin
         tick(1);
         check(resultData, code, "held result");
         check(endOfConv, 1'b1, "held done");
      end
   endtask

   task automatic freeze_run();
      convert(8'h3C, 2'd1, 1'b0);
      @(posedge clock) startReg <= 1'b1;
      @(posedge clock) startReg <= 1'b0;
      tick(10);
      @(posedge clock) clockEnable <= 1'b0;
      #1;
      snap = dacBits;
      repeat (5)
      begin
         tick(1);
         check(dacBits, snap, "frozen dac");
      end
      @(posedge clock) clockEnable <= 1'b1;
      for (int w = 0; w < 60 && endOfConv !== 1'b1; w++)
         tick(1);
      check(resultData, 8'h3C, "result after freeze");
   endtask

   task automatic continuous_run();
      int pulses;
      pulses = 0;
      @(posedge clock);
      vinCode  <= 8'hC3;
      loopMode <= 1'b1;
      repeat (150)
      begin
         tick(1);
         if (initStrobe === 1'b1)
            pulses++;
         if (endOfConv === 1'b1 && pulses > 1)
            check(resultData, 8'hC3, "looped result");
      end
      check(pulses >= 3, 1'b1, "continuous restarts");
      @(posedge clock) loopMode <= 1'b0;
      tick(60);
   endtask

   task automatic reset_mid_run();
      @(posedge clock) startReg <= 1'b1;
      @(posedge clock) startReg <= 1'b0;
      tick(12);
      @(posedge clock) reset_n <= 1'b0;
      tick(1);
      check(dacBits | resultData, 8'h00, "reset clears");
      check({6'h0, convPhase}, {6'h0, ST_IDLE}, "reset idle");
      @(posedge clock) reset_n <= 1'b1;
      tick(10);
      check({6'h0, convPhase}, {6'h0, ST_IDLE}, "no start after reset");
   endtask

   // ****
   // run
   // ****
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial
   begin
      repeat (8000) @(posedge clock);
      fails++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end

   initial
   begin
      logic [7:0] codes [8];
      codes = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h55, 8'hAA, 8'h01, 8'hFE};
      reset_n     = 1'b0;
      clockEnable = 1'b1;
      startReg    = 1'b0;
      loopMode    = 1'b0;
      vinCode     = 8'h00;
      lagCycles   = 2'd0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      tick(4);
      for (int i = 0; i < 8; i++)
         convert(codes[i], 2'(i % 2), i == 3);
      freeze_run();
      continuous_run();
      reset_mid_run();
      convert(8'h96, 2'h1, 1'b0);
      close_out();
   end
endmodule // testbench
